//--- modulo_tick_counter.sv
// modulo tick counter with source select, predivider and wrap events
// How it works
// - count advances once per divided tick
// - match with shadow wraps to zero, signals overflow
// - soft restart clears count, reloads shadow quietly
// - count is read only
// - writable limit plus hidden shadow for compare
// - source select resets to stopped
// - stopped or dead source holds count
// - passthrough or divide by listed ratios
// - wrap with enable raises interrupt request
// - every wrap emits one trigger pulse
// - power state restricts usable sources
// - shadow loads only on wrap or restart
// - wrap flag sticks until vector read
// - source codes stop, device, crystal, very low
// - prescale codes 1,10,100,1000,16,64,256,1024
`timescale 1ns/10ps

module modulo_tick_counter
    import mtc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // source clock pins
    input wire logic subMainClock,
    input wire logic auxClock,
    input wire logic crystalClock,
    input wire logic veryLowOscClock,
    // power state
    input wire mtc_power_type powerState,
    // control word
    input wire logic controlWrite,
    input wire mtc_control_type controlData,
    input wire logic softRestart,
    // limit register
    input wire logic wrapLimitWrite,
    input wire logic [MTC_COUNT_W-1:0] wrapLimitData,
    // vector read strobe
    input wire logic irqVectorRead,
    // status and readback
    output mtc_control_type control,
    output logic [MTC_COUNT_W-1:0] wrapLimit,
    output logic [MTC_COUNT_W-1:0] tickCount,
    output logic [MTC_COUNT_W-1:0] irqVector,
    output logic wrapFlag,
    output logic wrapIrq,
    output logic wrapTrigger
);

    // ==========================================
    // synchronisers, one per source pin
    logic [3:0] srcPin;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncC;

    assign srcPin = {veryLowOscClock, crystalClock, auxClock, subMainClock};

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sync
            // first stage feeds only the second
            always_ff @(posedge clk_sys)
            begin
                if (!nrst)
                begin
                    syncA[g] <= 1'b0;
                    syncB[g] <= 1'b0;
                    syncC[g] <= 1'b0;
                end
                else
                begin
                    syncA[g] <= srcPin[g];
                    syncB[g] <= syncA[g];
                    syncC[g] <= syncB[g];
                end
            end
        end
    endgenerate

    // ==========================================
    // control word
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            control <= MTC_CONTROL_RESET;
        end
        else if (controlWrite)
        begin
            control <= controlData;
        end
    end

    // ==========================================
    // source choice gated by power state
    logic [3:0] srcRise;
    logic srcEdge;
    logic deviceEdge;
    logic lowEdgeOk;
    logic deviceOk;

    assign srcRise = syncB & ~syncC;

    // device source is sub-main in active and light sleep, aux in intermediate sleep
    always_comb
    begin
        deviceEdge = 1'b0;
        deviceOk = 1'b0;
        lowEdgeOk = 1'b0;
        unique case (powerState)
            MTC_PWR_ACTIVE, MTC_PWR_LIGHT_SLEEP:
            begin
                deviceEdge = srcRise[0];
                deviceOk = 1'b1;
                lowEdgeOk = 1'b1;
            end
            MTC_PWR_INTERMEDIATE_SLEEP:
            begin
                deviceEdge = srcRise[1];
                deviceOk = 1'b1;
                lowEdgeOk = 1'b1;
            end
            MTC_PWR_RETAINED_DEEP_SLEEP:
            begin
                lowEdgeOk = 1'b1;
            end
            default:
            begin
                deviceOk = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        srcEdge = 1'b0;
        unique case (control.sourceSelect)
            MTC_SRC_STOP: srcEdge = 1'b0;
            MTC_SRC_DEVICE: srcEdge = deviceOk && deviceEdge;
            MTC_SRC_CRYSTAL: srcEdge = lowEdgeOk && srcRise[2];
            MTC_SRC_VERY_LOW: srcEdge = lowEdgeOk && srcRise[3];
        endcase
    end

    // ==========================================
    // predivider
    logic tick;

    mtc_prescaler u_prescaler (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .prescaleSelect(control.prescaleSelect),
        .restart(softRestart),
        .srcEdge(srcEdge),
        .tick(tick)
    );

    // ==========================================
    // limit register and shadow
    logic [MTC_COUNT_W-1:0] shadowLimit;
    logic reloadPending;
    logic wrap;

    assign wrap = tick && !reloadPending && (tickCount == shadowLimit);

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wrapLimit <= MTC_LIMIT_RESET;
        end
        else if (wrapLimitWrite)
        begin
            wrapLimit <= wrapLimitData;
        end
    end

    // last written limit wins because shadow samples only at the load moment
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            shadowLimit <= MTC_LIMIT_RESET;
        end
        else if (tick && (reloadPending || wrap))
        begin
            shadowLimit <= wrapLimit;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            reloadPending <= 1'b0;
        end
        else if (softRestart)
        begin
            reloadPending <= 1'b1;
        end
        else if (tick)
        begin
            reloadPending <= 1'b0;
        end
    end

    // ==========================================
    // tick count, no software write path exists
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tickCount <= MTC_COUNT_RESET;
        end
        else if (softRestart)
        begin
            tickCount <= MTC_COUNT_RESET;
        end
        else if (tick)
        begin
            if (wrap || reloadPending)
            begin
                tickCount <= MTC_COUNT_RESET;
            end
            else
            begin
                tickCount <= tickCount + 16'h0001;
            end
        end
    end

    // ==========================================
    // wrap events
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wrapTrigger <= 1'b0;
        end
        else
        begin
            wrapTrigger <= wrap;
        end
    end

    // set beats a read in the same cycle so no wrap is lost
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wrapFlag <= 1'b0;
            irqVector <= MTC_VECTOR_NONE;
        end
        else if (wrap)
        begin
            wrapFlag <= 1'b1;
            irqVector <= MTC_VECTOR_WRAP;
        end
        else if (irqVectorRead)
        begin
            wrapFlag <= 1'b0;
            irqVector <= MTC_VECTOR_NONE;
        end
    end

    // request follows flag and enable, a stale flag fires when enabled
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wrapIrq <= 1'b0;
        end
        else
        begin
            wrapIrq <= control.wrapIrqEnable && (wrap || (wrapFlag && !irqVectorRead));
        end
    end

endmodule // modulo_tick_counter

//--- modulo_tick_counter_bench.sv
// self-checking bench for the modulo tick counter
`timescale 1ns/10ps

// ========================================
// bench
module modulo_tick_counter_bench
    import mtc_pkg::*;
;
    logic clk_sys, nrst, subMainClock, auxClock, crystalClock, veryLowOscClock;
    logic controlWrite, softRestart, wrapLimitWrite, irqVectorRead;
    logic wrapFlag, wrapIrq, wrapTrigger;
    logic [15:0] wrapLimitData, wrapLimit, tickCount, irqVector;
    mtc_power_type powerState;
    mtc_control_type controlData, control;
    int fails, comparisons;
    int divs [8] = '{1, 10, 100, 1000, 16, 64, 256, 1024};

    modulo_tick_counter i_modulo_tick_counter (.clk_sys(clk_sys), .nrst(nrst),
        .subMainClock(subMainClock), .auxClock(auxClock), .crystalClock(crystalClock),
        .veryLowOscClock(veryLowOscClock), .powerState(powerState),
        .controlWrite(controlWrite), .controlData(controlData), .softRestart(softRestart),
        .wrapLimitWrite(wrapLimitWrite), .wrapLimitData(wrapLimitData),
        .irqVectorRead(irqVectorRead), .control(control), .wrapLimit(wrapLimit),
        .tickCount(tickCount), .irqVector(irqVector), .wrapFlag(wrapFlag),
        .wrapIrq(wrapIrq), .wrapTrigger(wrapTrigger));

    // ========================================
    // helpers
    task automatic ck16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ck1(input logic got, input logic exp);
        ck16({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic ctl(input mtc_control_type c);
        @(posedge clk_sys);
        controlData <= c;
        controlWrite <= 1'b1;
        @(posedge clk_sys);
        controlWrite <= 1'b0;
    endtask
    task automatic lim(input logic [15:0] v);
        @(posedge clk_sys);
        wrapLimitData <= v;
        wrapLimitWrite <= 1'b1;
        @(posedge clk_sys);
        wrapLimitWrite <= 1'b0;
    endtask
    task automatic str(input logic r, input logic v);
        @(posedge clk_sys);
        {softRestart, irqVectorRead} <= {r, v};
        @(posedge clk_sys);
        {softRestart, irqVectorRead} <= 2'h0;
    endtask
    // pins held 3 cycles each way, well inside the oversampling limit
    task automatic pulse(input int n, input logic [2:0] m);
        repeat (n)
        begin
            @(posedge clk_sys);
            {subMainClock, crystalClock, veryLowOscClock} <= m;
            cyc(3);
            {subMainClock, crystalClock, veryLowOscClock} <= 3'h0;
            cyc(3);
        end
        @(negedge clk_sys);
    endtask
    task automatic hit(input logic irqOn);
        int i;
        @(posedge clk_sys);
        crystalClock <= 1'b1;
        for (i = 0; i < 10 && wrapTrigger !== 1'b1; i++)
            @(negedge clk_sys);
        ck1(wrapTrigger, 1'b1);
        ck16(tickCount, 16'h0000);
        ck1(wrapFlag, 1'b1);
        ck16(irqVector, MTC_VECTOR_WRAP);
        ck1(wrapIrq, irqOn);
        @(negedge clk_sys);
        ck1(wrapTrigger, 1'b0);
        @(posedge clk_sys);
        crystalClock <= 1'b0;
        cyc(3);
    endtask

    // ========================================
    // scenarios
    task automatic t_reset;
        @(negedge clk_sys);
        ck16({10'h000, control}, 16'h0000);
        ck16(wrapLimit, 16'hBEEF);
        ck16(tickCount, 16'h0000);
        ck16(irqVector, 16'h0000);
        pulse(2, 3'h7);
        ck16(tickCount, 16'h0000);
    endtask
    task automatic t_wrap;
        ctl('{MTC_SRC_CRYSTAL, MTC_DIV_1, 1'b1});
        lim(16'h0002);
        str(1'b1, 1'b0);
        pulse(1, 3'h2);
        ck16(tickCount, 16'h0000);
        lim(16'h0007);
        lim(16'h0003);
        @(negedge clk_sys);
        ck16(wrapLimit, 16'h0003);
        pulse(2, 3'h2);
        ck16(tickCount, 16'h0002);
        ck1(wrapFlag, 1'b0);
        hit(1'b1);
        pulse(3, 3'h2);
        ck16(tickCount, 16'h0003);
        str(1'b0, 1'b1);
        cyc(1);
        @(negedge clk_sys);
        ck1(wrapFlag, 1'b0);
        ck1(wrapIrq, 1'b0);
        hit(1'b1);
    endtask
    task automatic t_gate;
        pulse(1, 3'h2);
        ck16(tickCount, 16'h0001);
        ctl('{MTC_SRC_STOP, MTC_DIV_1, 1'b0});
        pulse(2, 3'h7);
        ck16(tickCount, 16'h0001);
        ctl('{MTC_SRC_VERY_LOW, MTC_DIV_1, 1'b0});
        pulse(1, 3'h6);
        ck16(tickCount, 16'h0001);
        pulse(1, 3'h1);
        ck16(tickCount, 16'h0002);
        @(posedge clk_sys);
        powerState <= MTC_PWR_DEEPEST_SLEEP;
        pulse(1, 3'h1);
        ck16(tickCount, 16'h0002);
        ctl('{MTC_SRC_DEVICE, MTC_DIV_1, 1'b0});
        powerState <= MTC_PWR_INTERMEDIATE_SLEEP;
        pulse(1, 3'h4);
        ck16(tickCount, 16'h0002);
        @(posedge clk_sys);
        powerState <= MTC_PWR_ACTIVE;
        pulse(1, 3'h4);
        ck16(tickCount, 16'h0003);
        @(posedge clk_sys);
        powerState <= MTC_PWR_INTERMEDIATE_SLEEP;
        auxClock <= 1'b1;
        cyc(3);
        auxClock <= 1'b0;
        cyc(3);
        @(negedge clk_sys);
        ck16(tickCount, 16'h0000);
        @(posedge clk_sys);
        powerState <= MTC_PWR_RETAINED_DEEP_SLEEP;
        pulse(1, 3'h4);
        ck16(tickCount, 16'h0000);
        ctl('{MTC_SRC_CRYSTAL, MTC_DIV_1, 1'b0});
        // deep sleep ticks kept 25 us apart, slow enough for the low-power counter
        cyc(2500);
        pulse(1, 3'h2);
        ck16(tickCount, 16'h0001);
        @(posedge clk_sys);
        powerState <= MTC_PWR_ACTIVE;
    endtask
    // restart eats the first divided tick, so count 1 lands on edge 2N
    task automatic t_div;
        int i;
        lim(16'hFFFF);
        for (i = 0; i < 8; i++)
        begin
            ctl('{MTC_SRC_CRYSTAL, mtc_prescale_type'(i[2:0]), 1'b0});
            str(1'b1, 1'b0);
            pulse(2 * divs[i] - 1, 3'h2);
            ck16(tickCount, 16'h0000);
            pulse(1, 3'h2);
            ck16(tickCount, 16'h0001);
        end
    endtask

    // ========================================
    // run control
    task automatic wrap_up;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        #600000;
        fails++;
        wrap_up;
    end

    initial
    begin
        {nrst, subMainClock, auxClock, crystalClock, veryLowOscClock} = 5'h00;
        {controlWrite, softRestart, wrapLimitWrite, irqVectorRead} = 4'h0;
        powerState = MTC_PWR_ACTIVE;
        controlData = MTC_CONTROL_RESET;
        wrapLimitData = 16'h0000;
        cyc(3);
        nrst <= 1'b1;
        t_reset;
        t_wrap;
        t_gate;
        t_div;
        wrap_up;
    end
endmodule // modulo_tick_counter_bench

//--- mtc_checker_sva.sv
// port assertions for the modulo tick counter
`timescale 1ns/10ps

// ========================================
// checker
module mtc_checker
    import mtc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // strobes
    input wire logic softRestart,
    input wire logic irqVectorRead,
    // watched outputs
    input wire mtc_control_type control,
    input wire logic [MTC_COUNT_W-1:0] tickCount,
    input wire logic [MTC_COUNT_W-1:0] irqVector,
    input wire logic wrapFlag,
    input wire logic wrapIrq,
    input wire logic wrapTrigger
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_count_step: assert property ($changed(tickCount) |-> tickCount == 16'h0000
        || tickCount == $past(tickCount) + 16'h0001) else $error("count jumped");
    a_restart_clear: assert property (softRestart |=> tickCount == 16'h0000
        && !wrapTrigger) else $error("restart left count or wrapped");
    a_trig_single: assert property (wrapTrigger |=> !wrapTrigger)
        else $error("trigger longer than one cycle");
    a_trig_wraps: assert property (wrapTrigger |-> wrapFlag && tickCount == 16'h0000)
        else $error("trigger without flag or zero count");
    a_flag_hold: assert property (wrapFlag && !irqVectorRead |=> wrapFlag)
        else $error("flag dropped without read");
    a_flag_clear: assert property ($fell(wrapFlag) |-> $past(irqVectorRead))
        else $error("flag cleared without read");
    a_flag_rise: assert property ($rose(wrapFlag) |-> wrapTrigger)
        else $error("flag set without wrap");
    a_vector_code: assert property (irqVector == (wrapFlag ? MTC_VECTOR_WRAP
        : MTC_VECTOR_NONE)) else $error("vector does not follow flag");
    a_irq_cause: assert property (wrapIrq |-> $past(control.wrapIrqEnable)
        && ($past(wrapFlag) || wrapTrigger)) else $error("irq without cause");
    a_irq_fire: assert property (wrapTrigger && $past(control.wrapIrqEnable) |-> wrapIrq)
        else $error("enabled wrap gave no irq");
endmodule // mtc_checker

bind modulo_tick_counter mtc_checker i_mtc_checker (.clk_sys(clk_sys), .nrst(nrst),
    .softRestart(softRestart), .irqVectorRead(irqVectorRead), .control(control),
    .tickCount(tickCount), .irqVector(irqVector), .wrapFlag(wrapFlag), .wrapIrq(wrapIrq),
    .wrapTrigger(wrapTrigger));

//--- mtc_pkg.sv
// package of constants and types for the modulo tick counter
package mtc_pkg;

    // ==========================================
    // widths and reset values
    localparam int MTC_COUNT_W = 16;
    localparam logic [15:0] MTC_LIMIT_RESET = 16'hBEEF;
    localparam logic [15:0] MTC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] MTC_VECTOR_NONE = 16'h0000;
    localparam logic [15:0] MTC_VECTOR_WRAP = 16'h0002;
    localparam int MTC_SYNC_STAGES = 2;

    // ==========================================
    // source select codes
    typedef enum logic [1:0] {
        MTC_SRC_STOP = 2'h0,
        MTC_SRC_DEVICE = 2'h1,
        MTC_SRC_CRYSTAL = 2'h2,
        MTC_SRC_VERY_LOW = 2'h3
    } mtc_source_type;

    // ==========================================
    // prescale select codes
    typedef enum logic [2:0] {
        MTC_DIV_1 = 3'h0,
        MTC_DIV_10 = 3'h1,
        MTC_DIV_100 = 3'h2,
        MTC_DIV_1000 = 3'h3,
        MTC_DIV_16 = 3'h4,
        MTC_DIV_64 = 3'h5,
        MTC_DIV_256 = 3'h6,
        MTC_DIV_1024 = 3'h7
    } mtc_prescale_type;

    localparam int MTC_DIV_W = 10;
    localparam logic [MTC_DIV_W-1:0] MTC_DIV_TOP [8] = '{
        10'h000, 10'h009, 10'h063, 10'h3E7, 10'h00F, 10'h03F, 10'h0FF, 10'h3FF
    };

    // ==========================================
    // power states
    typedef enum logic [2:0] {
        MTC_PWR_ACTIVE = 3'h0,
        MTC_PWR_LIGHT_SLEEP = 3'h1,
        MTC_PWR_INTERMEDIATE_SLEEP = 3'h2,
        MTC_PWR_RETAINED_DEEP_SLEEP = 3'h3,
        MTC_PWR_DEEPEST_SLEEP = 3'h4
    } mtc_power_type;

    // ==========================================
    // control word carried as one bundle
    typedef struct packed {
        mtc_source_type sourceSelect;
        mtc_prescale_type prescaleSelect;
        logic wrapIrqEnable;
    } mtc_control_type;

    localparam mtc_control_type MTC_CONTROL_RESET = '{MTC_SRC_STOP, MTC_DIV_1, 1'b0};

endpackage

//--- mtc_prescaler.sv
// predivider that turns source clock edges into counter ticks
`timescale 1ns/10ps

module mtc_prescaler
    import mtc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control
    input wire mtc_prescale_type prescaleSelect,
    input wire logic restart,
    // source edge in, tick out
    input wire logic srcEdge,
    output logic tick
);

    // ==========================================
    // divider
    logic [MTC_DIV_W-1:0] divCount;
    logic [MTC_DIV_W-1:0] divTop;

    assign divTop = MTC_DIV_TOP[prescaleSelect];

    always_ff @(posedge clk_sys)
    begin
        if (!nrst || restart)
        begin
            divCount <= '0;
        end
        else if (srcEdge)
        begin
            if (divCount >= divTop)
            begin
                divCount <= '0;
            end
            else
            begin
                divCount <= divCount + 10'h001;
            end
        end
    end

    // passthrough gives top of zero, so every edge ticks
    assign tick = srcEdge && (divCount >= divTop) && !restart;

endmodule // mtc_prescaler
